// File: hw/srp_regs.vh
// register offsets, field positions, reset values and timing figures of the
// reference-pulse release, burst and delay logic; definitions only
`ifndef SRP_REGS_VH
`define SRP_REGS_VH

// register addresses
`define SRP_ADDR_RELEASE 8'h19
`define SRP_ADDR_COUNT 8'h1A
`define SRP_ADDR_DELAY 8'h1B
`define SRP_ADDR_MODE 8'h1C
`define SRP_ADDR_TRIGGER 8'h70

// field positions
`define SRP_REL_COMBINE 6
`define SRP_REL_UPPER_HI 5
`define SRP_REL_UPPER_LO 3
`define SRP_REL_LOWER_HI 2
`define SRP_REL_LOWER_LO 0
`define SRP_MODE_SOURCE 1
`define SRP_MODE_CONT 0
`define SRP_TRIG_BIT 7

// reset values
`define SRP_RST_RELEASE 7'h01
`define SRP_RST_COUNT 8'h02
`define SRP_RST_DELAY 8'h00
`define SRP_RST_SOURCE 1'b0
`define SRP_RST_CONT 1'b0

// delay step and full-scale figures in picoseconds
`define SRP_DELAY_STEP_PS 17'd339
`define SRP_DELAY_MAX_PS 17'd86466
// the full scale is spread over this many intervals between code 0 and all ones
`define SRP_DELAY_INTERVALS 25'd255

`endif

// File: hw/srp_ctrl.v
// reference-pulse release divider, counted burst generator and global
// reference delay, with the control registers behind a parallel register port
// assumes: the register port and all inputs are synchronous to clk_i, which is
// the device clock; chan_coinc_i marks edges where all channel dividers align
`timescale 1ns/100ps
`default_nettype none
`include "srp_regs.vh"

// Notes on behaviour
// - combine bit 0: release ratio comes from the lower stage field alone.
// - combine bit 1: release ratio is upper-stage ratio times lower-stage ratio.
// - upper codes give 2,4,6,8,4,8,12,16; lower codes give 2 through 9.
// - pulses leave only where release divider and channel dividers coincide.
// - exactly the programmed eight-bit count of pulses, on every enabled output.
// - counted burst follows each count write, only with internal pulse source and mode 0.
// - the global delay applies equally to all outputs set as pulse outputs.
// - delay is code times 86466/255 ps, 256 steps, 0 ps to 86.466 ns.
// - with internal source, mode select 0 gives counted bursts; mode select 1 gives continuous pulses.
// - trigger bit starts burst and realigns outputs, only with source and mode 0.
module srp_ctrl #(
  parameter NUM_OUT = 4
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // register port
  input wire [7:0] reg_addr_i,
  input wire [7:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [7:0] reg_rdata_o,
  // device clock path
  input wire chan_coinc_i,
  input wire ext_pulse_i,
  // per-output configuration
  input wire [NUM_OUT-1:0] out_enable_i,
  input wire [NUM_OUT-1:0] out_is_pulse_i,
  // pulse and delay outputs
  output reg [NUM_OUT-1:0] reference_pulse_output_o,
  output reg [8*NUM_OUT-1:0] ref_delay_code_o,
  output reg [16:0] ref_delay_ps_o,
  output reg [7:0] release_ratio_o,
  output reg realign_o,
  output reg burst_busy_o
);

  //----------------------------------------------------------------
  // registers and state
  //----------------------------------------------------------------
  reg [6:0] release_divider_setting_r;
  reg [7:0] pulse_burst_count_r;
  reg [7:0] global_reference_delay_r;
  reg pulse_source_select_r;
  reg pulse_mode_select_r;
  reg [7:0] rel_cnt_r;
  reg [7:0] remain_r;
  reg ext_prev_r;
  reg ext_pend_r;
  reg [7:0] ratio_nxt;
  reg [7:0] upper_ratio;
  reg [7:0] lower_ratio;
  reg [15:0] prod;
  wire wr_count;
  wire wr_trig;
  wire start_burst;
  wire release_edge;
  wire fire;
  wire [24:0] delay_scaled;
  integer i;

  //----------------------------------------------------------------
  // release ratio decode
  //----------------------------------------------------------------
  // upper stage is not monotonic in its code, hence the table
  always @* begin
    case (release_divider_setting_r[`SRP_REL_UPPER_HI:`SRP_REL_UPPER_LO])
      3'h0: upper_ratio = 8'h02;
      3'h1: upper_ratio = 8'h04;
      3'h2: upper_ratio = 8'h06;
      3'h3: upper_ratio = 8'h08;
      3'h4: upper_ratio = 8'h04;
      3'h5: upper_ratio = 8'h08;
      3'h6: upper_ratio = 8'h0C;
      default: upper_ratio = 8'h10;
    endcase
    lower_ratio = {5'h00, release_divider_setting_r[`SRP_REL_LOWER_HI:`SRP_REL_LOWER_LO]}
      + 8'h02;
    prod = upper_ratio * lower_ratio; // at most 144, fits 8 bits
    if (release_divider_setting_r[`SRP_REL_COMBINE])
      ratio_nxt = prod[7:0];
    else
      ratio_nxt = lower_ratio;
  end

  //----------------------------------------------------------------
  // decode of write strobes
  //----------------------------------------------------------------
  assign wr_count = reg_wr_i && (reg_addr_i == `SRP_ADDR_COUNT);
  assign wr_trig = reg_wr_i && (reg_addr_i == `SRP_ADDR_TRIGGER) &&
    reg_wdata_i[`SRP_TRIG_BIT];
  // counted burst needs internal source and counted mode
  assign start_burst = (wr_count || wr_trig) && !pulse_source_select_r &&
    !pulse_mode_select_r;
  // release only where the divider wraps together with the channel dividers
  assign release_edge = (rel_cnt_r == 8'h00) && chan_coinc_i;
  // one pulse per release edge, by the active source and mode
  assign fire = release_edge && (pulse_source_select_r ? ext_pend_r :
    (pulse_mode_select_r ? 1'b1 : (remain_r != 8'h00)));

  // full scale spread over 255 intervals makes the step a shade above 339 ps;
  // a plain code times 339 would end 21 ps short of the top of the range
  assign delay_scaled = ({17'h00000, global_reference_delay_r} *
    {8'h00, `SRP_DELAY_MAX_PS}) / `SRP_DELAY_INTERVALS;

  //----------------------------------------------------------------
  // control registers
  //----------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      release_divider_setting_r <= `SRP_RST_RELEASE;
      pulse_burst_count_r <= `SRP_RST_COUNT;
      global_reference_delay_r <= `SRP_RST_DELAY;
      pulse_source_select_r <= `SRP_RST_SOURCE;
      pulse_mode_select_r <= `SRP_RST_CONT;
    end else if (reg_wr_i) begin
      case (reg_addr_i)
        `SRP_ADDR_RELEASE: release_divider_setting_r <= reg_wdata_i[6:0];
        `SRP_ADDR_COUNT: pulse_burst_count_r <= reg_wdata_i;
        `SRP_ADDR_DELAY: global_reference_delay_r <= reg_wdata_i;
        `SRP_ADDR_MODE: begin
          pulse_source_select_r <= reg_wdata_i[`SRP_MODE_SOURCE];
          pulse_mode_select_r <= reg_wdata_i[`SRP_MODE_CONT];
        end
        default: ;
      endcase
    end
  end

  //----------------------------------------------------------------
  // read port
  //----------------------------------------------------------------
  // trigger register is write only and reads zero, as do unmapped addresses
  always @(posedge clk_i) begin
    if (rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `SRP_ADDR_RELEASE: reg_rdata_o <= {1'b0, release_divider_setting_r};
        `SRP_ADDR_COUNT: reg_rdata_o <= pulse_burst_count_r;
        `SRP_ADDR_DELAY: reg_rdata_o <= global_reference_delay_r;
        `SRP_ADDR_MODE: reg_rdata_o <= {6'h00, pulse_source_select_r, pulse_mode_select_r};
        default: reg_rdata_o <= 8'h00;
      endcase
    end
  end

  //----------------------------------------------------------------
  // release divider, burst counter and external request
  //----------------------------------------------------------------
  // the trigger, with internal source and mode 0 only, restarts the divider phase so outputs line up with the clocks
  always @(posedge clk_i) begin
    if (rst_i) begin
      rel_cnt_r <= 8'h00;
      remain_r <= 8'h00;
      ext_prev_r <= 1'b0;
      ext_pend_r <= 1'b0;
      realign_o <= 1'b0;
    end else begin
      realign_o <= wr_trig && !pulse_source_select_r && !pulse_mode_select_r;
      if (wr_trig && !pulse_source_select_r && !pulse_mode_select_r)
        rel_cnt_r <= 8'h00;
      else if (rel_cnt_r == 8'h00)
        rel_cnt_r <= chan_coinc_i ? ratio_nxt - 8'h01 : 8'h00;
      else
        rel_cnt_r <= rel_cnt_r - 8'h01;
      // a new start reloads the full count; a pulse on the same edge is dropped.
      // a count write starts with the value being written, so the burst length
      // always matches what software has just programmed
      if (wr_count && start_burst)
        remain_r <= reg_wdata_i;
      else if (start_burst)
        remain_r <= pulse_burst_count_r;
      else if (fire && !pulse_source_select_r && !pulse_mode_select_r)
        remain_r <= remain_r - 8'h01;
      ext_prev_r <= ext_pulse_i;
      // set wins over the clear made by a release in the same cycle
      if (ext_pulse_i && !ext_prev_r)
        ext_pend_r <= 1'b1;
      else if (release_edge)
        ext_pend_r <= 1'b0;
    end
  end

  //----------------------------------------------------------------
  // outputs
  //----------------------------------------------------------------
  // delay lines are analog; this block hands them the code and its value in ps
  always @(posedge clk_i) begin
    if (rst_i) begin
      reference_pulse_output_o <= {NUM_OUT{1'b0}};
      ref_delay_code_o <= {8*NUM_OUT{1'b0}};
      ref_delay_ps_o <= 17'h00000;
      release_ratio_o <= 8'h00;
      burst_busy_o <= 1'b0;
    end else begin
      reference_pulse_output_o <= (fire && !start_burst) ?
        out_enable_i : {NUM_OUT{1'b0}};
      for (i = 0; i < NUM_OUT; i = i + 1) begin
        ref_delay_code_o[8*i +: 8] <= out_is_pulse_i[i] ?
          global_reference_delay_r : 8'h00;
      end
      ref_delay_ps_o <= delay_scaled[16:0];
      release_ratio_o <= ratio_nxt;
      burst_busy_o <= (remain_r != 8'h00) && !pulse_source_select_r &&
        !pulse_mode_select_r;
    end
  end

endmodule // srp_ctrl
`default_nettype wire

// File: verif/srp_ctrl_sva.sv
// checker for the reference-pulse control block
// assumes: bound onto srp_ctrl, one clock domain clk_i
`timescale 1ns/100ps
`default_nettype none
`include "srp_regs.vh"
module srp_ctrl_sva #(parameter NUM_OUT = 4) (
  // clock, reset and register port
  input wire logic clk_i, rst_i, reg_wr_i, reg_rd_i,
  input wire logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, release_ratio_o,
  // pulse path
  input wire logic chan_coinc_i, realign_o,
  input wire logic [NUM_OUT-1:0] out_enable_i, out_is_pulse_i, reference_pulse_output_o,
  input wire logic [8*NUM_OUT-1:0] ref_delay_code_o,
  input wire logic [16:0] ref_delay_ps_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0] d1_r, d2_r;
  wire wr_rel = reg_wr_i && reg_addr_i == `SRP_ADDR_RELEASE;
  wire wr_dly = reg_wr_i && reg_addr_i == `SRP_ADDR_DELAY;
  wire wr_trg = reg_wr_i && reg_addr_i == `SRP_ADDR_TRIGGER && reg_wdata_i[7];
  // upper stage ratios are not monotonic, so they come from the code bits
  function automatic logic [7:0] up_ratio(input logic [2:0] c);
    return (8'(c[1:0]) + 8'h01) << (c[2] ? 2 : 1);
  endfunction
  // write data delayed to the cycle where decoded outputs settle
  always_ff @(posedge clk_i) begin
    d1_r <= reg_wdata_i;
    d2_r <= d1_r;
  end
  // full scale over 255 intervals: code 1 gives 339 ps, all ones 86466 ps
  a_delay_ps_value: assert property (wr_dly |->
    ##2 ref_delay_ps_o == 17'((25'(d2_r) * 25'd86466) / 25'd255))
    else $error("delay in ps does not follow the code");
  a_delay_code_map: assert property (wr_dly |-> ##2 ref_delay_code_o[15:0] ==
    {out_is_pulse_i[1] ? d2_r : 8'h00, out_is_pulse_i[0] ? d2_r : 8'h00})
    else $error("per-output delay code wrong");
  a_ratio_lower_only: assert property (wr_rel && !reg_wdata_i[6] |->
    ##2 release_ratio_o == 8'(d2_r[2:0]) + 8'h02) else $error("lower-stage ratio wrong");
  a_ratio_stage_product: assert property (wr_rel && reg_wdata_i[6] |->
    ##2 release_ratio_o == up_ratio(d2_r[5:3]) * (8'(d2_r[2:0]) + 8'h02))
    else $error("combined ratio wrong");
  a_pulse_on_coinc: assert property (|reference_pulse_output_o |-> $past(chan_coinc_i))
    else $error("pulse without coincident edge");
  a_pulse_all_enabled: assert property (|reference_pulse_output_o |->
    reference_pulse_output_o == $past(out_enable_i)) else $error("pulse lanes differ from enables");
  a_realign_after_trig: assert property (realign_o |-> $past(wr_trg))
    else $error("realign without trigger write");
  a_trig_reads_zero: assert property (reg_rd_i && reg_addr_i == `SRP_ADDR_TRIGGER |=>
    reg_rdata_o == 8'h00) else $error("trigger location not read as zero");
  c_pulse: cover property (|reference_pulse_output_o);
  c_realign: cover property (realign_o);
  c_combined: cover property (wr_rel && reg_wdata_i[6]);
endmodule // srp_ctrl_sva
bind srp_ctrl srp_ctrl_sva #(.NUM_OUT(NUM_OUT)) chk_u (.*);
`default_nettype wire

// File: verif/srp_ctrl_tb.sv
// self-checking bench for srp_ctrl: register tasks, pulse counting
// assumes: the checker is bound from its own file, coincidence held high until the last test drops it
`timescale 1ns/100ps
`default_nettype none
`include "srp_regs.vh"
module srp_ctrl_tb;
  logic clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic chan_coinc_i = 1'b1, ext_pulse_i = 1'b0, realign_o, burst_busy_o;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o, release_ratio_o;
  logic [3:0] out_enable_i = 4'hB, out_is_pulse_i = 4'h5, reference_pulse_output_o;
  logic [31:0] ref_delay_code_o;
  logic [16:0] ref_delay_ps_o;
  logic [7:0] up_t [8] = '{8'h02, 8'h04, 8'h06, 8'h08, 8'h04, 8'h08, 8'h0C, 8'h10};
  int n_fail = 0, cmp_count = 0, i;
  always #20 clk_i = ~clk_i;
  srp_ctrl #(.NUM_OUT(4)) dut_u (.*);
  task automatic chk(input logic [31:0] got, exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // write, then one more cycle so decoded outputs have settled
  task automatic wr(input logic [7:0] a, d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
    @(negedge clk_i);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    chk(reg_rdata_o, exp);
  endtask
  // count pulses over a fixed window; lanes must match the enables
  task automatic pulses(input int n, input int exp);
    int c;
    c = 0;
    // sample at once: the first pulse may already stand when wr returns
    repeat (n) begin
      if (|reference_pulse_output_o) begin
        c++;
        chk(reference_pulse_output_o, out_enable_i);
      end
      @(negedge clk_i);
    end
    chk(c, exp);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    rd(`SRP_ADDR_RELEASE, 8'h01);
    rd(`SRP_ADDR_COUNT, 8'h02);
    rd(`SRP_ADDR_DELAY, 8'h00);
    rd(`SRP_ADDR_TRIGGER, 8'h00);
    rd(`SRP_ADDR_MODE, 8'h00);
    $display("test reset values done");
    for (i = 0; i < 8; i++) begin
      wr(`SRP_ADDR_RELEASE, 8'(i));
      chk(release_ratio_o, i + 2);
      wr(`SRP_ADDR_RELEASE, 8'(8'h40 + i * 8));
      chk(release_ratio_o, up_t[i] * 2);
    end
    wr(`SRP_ADDR_RELEASE, 8'h4E);
    chk(release_ratio_o, 32'h20);
    $display("test release ratio done");
    wr(`SRP_ADDR_DELAY, 8'hFF);
    chk(ref_delay_ps_o, 32'd86466);
    chk(ref_delay_code_o, 32'h00FF00FF);
    wr(`SRP_ADDR_DELAY, 8'h01);
    chk(ref_delay_ps_o, 32'd339);
    $display("test delay done");
    // ratio 3 stands for the common multiple of the channel dividers
    wr(`SRP_ADDR_RELEASE, 8'h01);
    wr(`SRP_ADDR_TRIGGER, 8'h80);
    pulses(20, 2);
    chk(burst_busy_o, 1'b0);
    wr(`SRP_ADDR_COUNT, 8'h03);
    pulses(20, 3);
    wr(`SRP_ADDR_TRIGGER, 8'h80);
    pulses(20, 3);
    wr(`SRP_ADDR_MODE, 8'h02);
    wr(`SRP_ADDR_TRIGGER, 8'h80);
    pulses(20, 0);
    // external source: one rising request gives one pulse at a release edge
    ext_pulse_i = 1'b1;
    pulses(20, 1);
    ext_pulse_i = 1'b0;
    wr(`SRP_ADDR_MODE, 8'h01);
    repeat (4) @(negedge clk_i);
    pulses(30, 10);
    wr(`SRP_ADDR_MODE, 8'h00);
    chan_coinc_i = 1'b0;
    wr(`SRP_ADDR_TRIGGER, 8'h80);
    pulses(20, 0);
    chk(burst_busy_o, 1'b1);
    $display("test pulse bursts done");
    end_sim();
  end
endmodule // srp_ctrl_tb
`default_nettype wire
